// ===== compare_carry_checker.sv
`timescale 1ns/1ps
// ============================================================
// Checker on the core ports
module compare_carry_checker (
  input wire logic                         i_clk,
  input wire logic                         i_rst,
  input wire logic                         i_bus8,
  input wire logic                         i_start,
  input wire compare_carry_pkg::exec_req_t i_req,
  input wire logic [15:0]                  i_acc,
  input wire logic [15:0]                  i_reg_val,
  input wire logic [15:0]                  i_rm_val,
  input wire logic [15:0]                  i_src_index,
  input wire logic [15:0]                  i_dst_index,
  input wire logic [15:0]                  i_flags,
  input wire logic                         o_ready,
  input wire logic                         o_mem_valid,
  input wire compare_carry_pkg::mem_req_t  o_mem_req,
  input wire logic                         i_mem_ack,
  input wire logic [15:0]                  i_mem_data,
  input wire logic                         o_done,
  input wire logic                         o_illegal,
  input wire logic                         o_flags_we,
  input wire logic [15:0]                  o_flags,
  input wire logic                         o_index_we,
  input wire logic [15:0]                  o_src_index,
  input wire logic [15:0]                  o_dst_index
);
  logic        acc;
  logic        str;
  logic        nf_q;
  logic [7:0]  op_q;
  logic [15:0] fl_q, si_q, dst_q, st;
  logic [5:0]  cnt_q;
  logic [4:0]  min_q;
  assign acc = i_start && o_ready;
  assign str = op_q[7:1] == 7'h53;
  assign st  = op_q[0] ? 16'h0002 : 16'h0001;

  // ============================================================
  // Captures at accept
  always_ff @(posedge i_clk) begin
    if (acc) begin
      op_q <= i_req.opcode;
      fl_q <= i_flags;
      si_q <= i_src_index;
      dst_q <= i_dst_index;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || acc) nf_q <= 1'b0;
    else if (i_mem_ack) nf_q <= 1'b1;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 6'h00;
      min_q <= 5'h00;
    end else if (acc) begin
      cnt_q <= 6'h00;
      min_q <= (i_req.opcode == 8'hf5) ? 5'h02 : (i_req.opcode[7:1] != 7'h53) ? 5'h00 :
               (i_req.opcode[0] && i_bus8) ? 5'h1a : 5'h16;
    end else if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  flip_timing_a: assert property (acc && i_req.opcode == 8'hf5 |->
    ##1 (!o_done)[*2] ##1 o_done)
    else $error("carry complement timing wrong");
  flip_carry_a: assert property (o_flags_we && op_q == 8'hf5 |->
    o_flags == (fl_q ^ 16'h0001))
    else $error("carry complement flags wrong");
  acc_lat_a: assert property (acc && i_req.opcode == 8'h3c |->
    ##1 (!o_done)[*3] ##1 o_done)
    else $error("accumulator compare timing wrong");
  str_lat_a: assert property (o_done |-> cnt_q >= {1'b0, min_q})
    else $error("done too early");
  keep_ctrl_a: assert property (o_flags_we |-> (o_flags & 16'hf700) == (fl_q & 16'hf700))
    else $error("control flags changed");
  index_step_a: assert property (o_index_we |->
    o_src_index == (fl_q[10] ? si_q - st : si_q + st) &&
    o_dst_index == (fl_q[10] ? dst_q - st : dst_q + st))
    else $error("index step wrong");
  index_str_a: assert property (o_done || o_index_we |->
    o_done && o_flags_we && o_index_we == str)
    else $error("index write wrong");
  group_refuse_a: assert property (acc && i_req.opcode == 8'h80 &&
    i_req.modrm[5:3] != 3'h7 |=> o_illegal && !o_flags_we)
    else $error("group opcode not refused");
  dst_seg_a: assert property (o_mem_valid && str && nf_q |->
    o_mem_req.addr == dst_q && o_mem_req.seg == compare_carry_pkg::SEG_EXTRA)
    else $error("destination fetch wrong");
  fetch_hold_a: assert property (o_mem_valid && !i_mem_ack |=>
    o_mem_valid && $stable(o_mem_req))
    else $error("fetch dropped");
endmodule // compare_carry_checker

bind compare_carry_exec compare_carry_checker chk_i (
  .i_clk, .i_rst, .i_bus8, .i_start, .i_req, .i_acc, .i_reg_val, .i_rm_val, .i_src_index,
  .i_dst_index, .i_flags, .o_ready, .o_mem_valid, .o_mem_req, .i_mem_ack, .i_mem_data,
  .o_done, .o_illegal, .o_flags_we, .o_flags, .o_index_we, .o_src_index, .o_dst_index
);

// ===== compare_carry_exec.sv
`timescale 1ns/1ps
module compare_carry_exec (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_bus8,
  input  wire logic                       i_start,
  input  wire compare_carry_pkg::exec_req_t i_req,
  input  wire logic [15:0]                i_acc,
  input  wire logic [15:0]                i_reg_val,
  input  wire logic [15:0]                i_rm_val,
  input  wire logic [15:0]                i_src_index,
  input  wire logic [15:0]                i_dst_index,
  input  wire logic [15:0]                i_flags,
  output logic                            o_ready,
  output logic                            o_mem_valid,
  output compare_carry_pkg::mem_req_t     o_mem_req,
  input  wire logic                       i_mem_ack,
  input  wire logic [15:0]                i_mem_data,
  output logic                            o_done,
  output logic                            o_illegal,
  output logic                            o_flags_we,
  output logic [15:0]                     o_flags,
  output logic                            o_index_we,
  output logic [15:0]                     o_src_index,
  output logic [15:0]                     o_dst_index
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH_A, ST_FETCH_B, ST_COUNT} state_t;

  state_t      state_q;
  logic [4:0]  cnt_q;
  logic [4:0]  lat_q;
  logic        word_q;
  logic        swap_q;
  logic        flip_q;
  logic        str_q;
  logic [15:0] x_q;
  logic [15:0] y_q;
  logic [15:0] flags_in_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;

  // ==========================================================================
  // Decode
  logic        dec_ok;
  logic        dec_word;
  logic        dec_swap;
  logic        dec_flip;
  logic        dec_str;
  logic        dec_mem;
  logic [4:0]  dec_lat;
  logic [15:0] dec_x;
  logic [15:0] dec_y;
  logic [15:0] imm_sext;
  logic        reg_is_compare;
  logic        accept;

  assign reg_is_compare = i_req.modrm[compare_carry_pkg::MODRM_REG_MSB:
                                      compare_carry_pkg::MODRM_REG_LSB]
                          == compare_carry_pkg::REG_FIELD_COMPARE;
  assign imm_sext = i_req.imm[7] ? (compare_carry_pkg::SEXT_NEG_FILL | i_req.imm)
                                 : (compare_carry_pkg::BYTE_MASK & i_req.imm);
  assign accept   = i_start && (state_q == ST_IDLE);

  function automatic logic [4:0] rm_lat(input logic mem, input logic word, input logic bus8);
    if (!mem) begin
      rm_lat = compare_carry_pkg::LAT_COMPARE_REG;
    end else if (word && bus8) begin
      rm_lat = compare_carry_pkg::LAT_COMPARE_MEM_WORD8;
    end else begin
      rm_lat = compare_carry_pkg::LAT_COMPARE_MEM;
    end
  endfunction

  always_comb begin
    dec_ok   = 1'b1;
    dec_word = i_req.opcode[compare_carry_pkg::OPC_WORD_BIT];
    dec_swap = 1'b0;
    dec_flip = 1'b0;
    dec_str  = 1'b0;
    dec_mem  = 1'b0;
    dec_lat  = compare_carry_pkg::LAT_COMPARE_REG;
    dec_x    = i_rm_val;
    dec_y    = i_reg_val;
    unique case (i_req.opcode)
      compare_carry_pkg::OPC_CARRY_COMPLEMENT: begin
        dec_flip = 1'b1;
        dec_lat = compare_carry_pkg::LAT_CARRY_COMPLEMENT;
      end
      compare_carry_pkg::OPC_COMPARE_ACC_BYTE: begin
        dec_word = 1'b0;
        dec_x    = i_acc;
        dec_y    = i_req.imm;
        dec_lat  = compare_carry_pkg::LAT_COMPARE_ACC_BYTE;
      end
      compare_carry_pkg::OPC_COMPARE_ACC_WORD: begin
        dec_word = 1'b1;
        dec_x    = i_acc;
        dec_y    = i_req.imm;
        dec_lat  = compare_carry_pkg::LAT_COMPARE_ACC_WORD;
      end
      compare_carry_pkg::OPC_GRP_IMM_BYTE,
      compare_carry_pkg::OPC_GRP_IMM_WORD,
      compare_carry_pkg::OPC_GRP_IMM_SEXT: begin
        dec_ok   = reg_is_compare;
        dec_mem  = i_req.rm_is_mem;
        dec_y    = (i_req.opcode == compare_carry_pkg::OPC_GRP_IMM_SEXT) ? imm_sext
                                                                         : i_req.imm;
        dec_word = i_req.opcode != compare_carry_pkg::OPC_GRP_IMM_BYTE;
        dec_lat  = rm_lat(i_req.rm_is_mem, dec_word, i_bus8);
      end
      compare_carry_pkg::OPC_COMPARE_RM_R_BYTE,
      compare_carry_pkg::OPC_COMPARE_RM_R_WORD,
      compare_carry_pkg::OPC_COMPARE_R_RM_BYTE,
      compare_carry_pkg::OPC_COMPARE_R_RM_WORD: begin
        dec_swap = i_req.opcode[compare_carry_pkg::OPC_DIR_BIT];
        dec_mem  = i_req.rm_is_mem;
        dec_lat  = rm_lat(i_req.rm_is_mem, dec_word, i_bus8);
      end
      compare_carry_pkg::OPC_COMPARE_STR_BYTE,
      compare_carry_pkg::OPC_COMPARE_STR_WORD: begin
        dec_str = 1'b1;
        dec_mem = 1'b1;
        dec_lat = (dec_word && i_bus8) ? compare_carry_pkg::LAT_STR_WORD8
                                       : compare_carry_pkg::LAT_STR;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Sequencing
  logic finish;
  assign finish  = (state_q == ST_COUNT) && (cnt_q >= lat_q);
  assign o_ready = state_q == ST_IDLE;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
    end else begin
      if (state_q != ST_IDLE && cnt_q < lat_q) begin
        cnt_q <= cnt_q + compare_carry_pkg::CNT_ONE;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (accept && dec_ok) begin
            cnt_q   <= compare_carry_pkg::CNT_ONE;
            state_q <= dec_mem ? ST_FETCH_A : ST_COUNT;
          end
        end
        ST_FETCH_A: begin
          if (i_mem_ack) begin
            state_q <= str_q ? ST_FETCH_B : ST_COUNT;
          end
        end
        ST_FETCH_B: begin
          if (i_mem_ack) begin
            state_q <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (finish) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Operand capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lat_q      <= 5'h00;
      word_q     <= 1'b0;
      swap_q     <= 1'b0;
      flip_q     <= 1'b0;
      str_q      <= 1'b0;
      x_q        <= 16'h0000;
      y_q        <= 16'h0000;
      flags_in_q <= 16'h0000;
      src_q      <= 16'h0000;
      dst_q      <= 16'h0000;
    end else if (accept && dec_ok) begin
      lat_q      <= dec_lat;
      word_q     <= dec_word;
      swap_q     <= dec_swap;
      flip_q     <= dec_flip;
      str_q      <= dec_str;
      x_q        <= dec_x;
      y_q        <= dec_y;
      flags_in_q <= i_flags;
      src_q      <= i_src_index;
      dst_q      <= i_dst_index;
    end else if (state_q == ST_FETCH_A && i_mem_ack) begin
      x_q <= i_mem_data;
    end else if (state_q == ST_FETCH_B && i_mem_ack) begin
      y_q <= i_mem_data;
    end
  end

  // ==========================================================================
  // Memory requests
  assign o_mem_valid = (state_q == ST_FETCH_A) || (state_q == ST_FETCH_B);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_req <= '0;
    end else if (accept && dec_ok) begin
      o_mem_req.word <= dec_word;
      o_mem_req.addr <= dec_str ? i_src_index : i_req.ea;
      o_mem_req.seg  <= dec_str ? (i_req.override_valid ? i_req.override_seg
                                                        : compare_carry_pkg::SEG_DATA)
                                : i_req.ea_seg;
    end else if (state_q == ST_FETCH_A && i_mem_ack && str_q) begin
      o_mem_req.addr <= dst_q;
      o_mem_req.seg  <= compare_carry_pkg::SEG_EXTRA;
    end
  end

  // ==========================================================================
  // Subtraction and flags
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [16:0] diff;
  logic [15:0] res;
  logic        res_msb;
  logic        a_msb;
  logic        b_msb;
  logic        borrow;
  logic [15:0] flags_new;

  always_comb begin
    op_a    = swap_q ? y_q : x_q;
    op_b    = swap_q ? x_q : y_q;
    if (!word_q) begin
      op_a = op_a & compare_carry_pkg::BYTE_MASK;
      op_b = op_b & compare_carry_pkg::BYTE_MASK;
    end
    diff    = {1'b0, op_a} - {1'b0, op_b};
    res     = word_q ? diff[15:0] : (diff[15:0] & compare_carry_pkg::BYTE_MASK);
    res_msb = word_q ? res[15] : res[7];
    a_msb   = word_q ? op_a[15] : op_a[7];
    b_msb   = word_q ? op_b[15] : op_b[7];
    borrow  = op_a < op_b;
    flags_new = flags_in_q;
    if (flip_q) begin
      flags_new[compare_carry_pkg::FLAG_CARRY] =
        ~flags_in_q[compare_carry_pkg::FLAG_CARRY];
    end else begin
      flags_new[compare_carry_pkg::FLAG_CARRY] = borrow;
      flags_new[compare_carry_pkg::FLAG_PF] = ~^res[7:0];
      flags_new[compare_carry_pkg::FLAG_AF] = op_a[4] ^ op_b[4] ^ res[4];
      flags_new[compare_carry_pkg::FLAG_ZF] = res == 16'h0000;
      flags_new[compare_carry_pkg::FLAG_SF] = res_msb;
      flags_new[compare_carry_pkg::FLAG_OF] = (a_msb ^ b_msb) & (a_msb ^ res_msb);
    end
  end

  // ==========================================================================
  // Index advance
  logic [15:0] step;
  logic        dir_down;
  assign step     = word_q ? compare_carry_pkg::STEP_WORD : compare_carry_pkg::STEP_BYTE;
  assign dir_down = flags_in_q[compare_carry_pkg::FLAG_DIRECTION];

  // ==========================================================================
  // Results
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_done      <= 1'b0;
      o_illegal   <= 1'b0;
      o_flags_we  <= 1'b0;
      o_flags     <= 16'h0000;
      o_index_we  <= 1'b0;
      o_src_index <= 16'h0000;
      o_dst_index <= 16'h0000;
    end else begin
      o_done     <= finish;
      o_illegal  <= accept && !dec_ok;
      o_flags_we <= finish;
      o_index_we <= finish && str_q;
      if (finish) begin
        o_flags <= flags_new;
      end
      if (finish && str_q) begin
        o_src_index <= dir_down ? (src_q - step) : (src_q + step);
        o_dst_index <= dir_down ? (dst_q - step) : (dst_q + step);
      end
    end
  end

endmodule // compare_carry_exec

// ===== compare_carry_pkg.sv
package compare_carry_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_CARRY_COMPLEMENT  = 8'hf5;
  localparam logic [7:0] OPC_COMPARE_ACC_BYTE  = 8'h3c;
  localparam logic [7:0] OPC_COMPARE_ACC_WORD  = 8'h3d;
  localparam logic [7:0] OPC_GRP_IMM_BYTE      = 8'h80;
  localparam logic [7:0] OPC_GRP_IMM_WORD      = 8'h81;
  localparam logic [7:0] OPC_GRP_IMM_SEXT      = 8'h83;
  localparam logic [7:0] OPC_COMPARE_RM_R_BYTE = 8'h38;
  localparam logic [7:0] OPC_COMPARE_RM_R_WORD = 8'h39;
  localparam logic [7:0] OPC_COMPARE_R_RM_BYTE = 8'h3a;
  localparam logic [7:0] OPC_COMPARE_R_RM_WORD = 8'h3b;
  localparam logic [7:0] OPC_COMPARE_STR_BYTE  = 8'ha6;
  localparam logic [7:0] OPC_COMPARE_STR_WORD  = 8'ha7;

  // ==========================================================================
  // Field layouts
  localparam int unsigned MODRM_REG_MSB     = 5;
  localparam int unsigned MODRM_REG_LSB     = 3;
  localparam logic [2:0]  REG_FIELD_COMPARE = 3'h7;
  localparam int unsigned OPC_WORD_BIT      = 0;
  localparam int unsigned OPC_DIR_BIT       = 1;

  localparam int unsigned FLAG_CARRY     = 0;
  localparam int unsigned FLAG_PF        = 2;
  localparam int unsigned FLAG_AF        = 4;
  localparam int unsigned FLAG_ZF        = 6;
  localparam int unsigned FLAG_SF        = 7;
  localparam int unsigned FLAG_DIRECTION = 10;
  localparam int unsigned FLAG_OF        = 11;

  localparam logic [15:0] SEXT_NEG_FILL  = 16'hff00;
  localparam logic [15:0] BYTE_MASK      = 16'h00ff;
  localparam logic [15:0] STEP_BYTE      = 16'h0001;
  localparam logic [15:0] STEP_WORD      = 16'h0002;

  // ==========================================================================
  // Clock counts per instruction
  localparam logic [4:0] LAT_CARRY_COMPLEMENT  = 5'h02;
  localparam logic [4:0] LAT_COMPARE_ACC_BYTE  = 5'h03;
  localparam logic [4:0] LAT_COMPARE_ACC_WORD  = 5'h04;
  localparam logic [4:0] LAT_COMPARE_REG       = 5'h03;
  localparam logic [4:0] LAT_COMPARE_MEM       = 5'h0a;
  localparam logic [4:0] LAT_COMPARE_MEM_WORD8 = 5'h0e;
  localparam logic [4:0] LAT_STR               = 5'h16;
  localparam logic [4:0] LAT_STR_WORD8         = 5'h1a;
  localparam logic [4:0] CNT_ONE               = 5'h01;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA
  } seg_sel_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic [15:0] imm;
    logic [15:0] ea;
    seg_sel_t    ea_seg;
    logic        rm_is_mem;
    logic        override_valid;
    seg_sel_t    override_seg;
  } exec_req_t;

  typedef struct packed {
    logic [15:0] addr;
    seg_sel_t    seg;
    logic        word;
  } mem_req_t;

endpackage

// ===== mem_partner.sv
`timescale 1ns/1ps
// ============================================================
// Memory side, acks i_wait+1 cycles after valid rises
module mem_partner (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_valid,
  input  wire compare_carry_pkg::mem_req_t i_req,
  input  wire logic [3:0]                  i_wait,
  output logic                             o_ack,
  output logic [15:0]                      o_data
);
  logic [3:0]  cnt_q;
  logic [15:0] p;
  assign p = {i_req.addr[7:0], i_req.addr[15:8]} ^ {14'h0, i_req.seg};
  always_ff @(posedge i_clk) begin
    o_ack  <= 1'b0;
    o_data <= ~o_data;
    if (i_rst) begin
      cnt_q  <= 4'h0;
      o_data <= 16'h0000;
    end else if (i_valid && !o_ack) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == i_wait) begin
        cnt_q  <= 4'h0;
        o_ack  <= 1'b1;
        o_data <= i_req.word ? p : {~p[15:8], p[7:0]};
      end
    end
  end
endmodule // mem_partner

// ===== tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Bench
module tb_top;
  logic                         i_clk, i_rst, i_bus8, i_start, i_mem_ack, ill;
  compare_carry_pkg::exec_req_t i_req;
  compare_carry_pkg::mem_req_t  o_mem_req;
  logic [15:0] i_acc, i_reg_val, i_rm_val, i_src_index, i_dst_index, i_flags, i_mem_data;
  logic        o_ready, o_mem_valid, o_done, o_illegal, o_flags_we, o_index_we;
  logic [15:0] o_flags, o_src_index, o_dst_index;
  logic [3:0]  mem_wait;
  int          bad_count, n_tests, cyc, n;

  compare_carry_exec uut (
    .i_clk, .i_rst, .i_bus8, .i_start, .i_req, .i_acc, .i_reg_val, .i_rm_val, .i_src_index,
    .i_dst_index, .i_flags, .o_ready, .o_mem_valid, .o_mem_req, .i_mem_ack, .i_mem_data,
    .o_done, .o_illegal, .o_flags_we, .o_flags, .o_index_we, .o_src_index, .o_dst_index);
  mem_partner mem_i (.i_clk, .i_rst, .i_valid(o_mem_valid), .i_req(o_mem_req),
    .i_wait(mem_wait), .o_ack(i_mem_ack), .o_data(i_mem_data));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      complete_run();
    end
  end

  // ============================================================
  // Helpers
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] mv(input logic [15:0] a, input logic [1:0] s);
    return {a[7:0], a[15:8]} ^ {14'h0, s};
  endfunction
  function automatic logic [15:0] sf(input logic [15:0] a, b, f, input logic w);
    logic [16:0] d;
    logic        s;
    d = w ? {1'b0, a} - {1'b0, b} : {9'h0, a[7:0]} - {9'h0, b[7:0]};
    s = w ? d[15] : d[7];
    f[0] = w ? d[16] : d[8];
    f[2] = ~^d[7:0];
    f[4] = a[4] ^ b[4] ^ d[4];
    f[6] = w ? d[15:0] == 16'h0 : d[7:0] == 8'h0;
    f[7] = s;
    f[11] = w ? a[15] != b[15] && s != a[15] : a[7] != b[7] && s != a[7];
    return f;
  endfunction
  function automatic compare_carry_pkg::exec_req_t rq(input logic [7:0] op, mm,
      input logic [15:0] imm, input logic mem, ov);
    return '{op, mm, imm, 16'h4321, compare_carry_pkg::SEG_DATA, mem, ov,
             compare_carry_pkg::SEG_STACK};
  endfunction
  task automatic fire(input compare_carry_pkg::exec_req_t q, input logic [15:0] a, r, m, f,
      input logic b8);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_req   <= q;
    i_acc   <= a;
    i_reg_val <= r;
    i_rm_val  <= m;
    i_flags <= f;
    i_bus8  <= b8;
    @(posedge i_clk);
    i_start <= 1'b0;
    n = 0;
    #1;
    ill = o_illegal === 1'b1;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (o_illegal === 1'b1) ill = 1'b1;
    end while (o_done !== 1'b1 && n < 40);
  endtask

  // ============================================================
  // Scenarios
  task automatic s_flip;
    for (int b = 0; b < 2; b++) begin
      fire(rq(8'hf5, 8'h00, 16'h0, 1'b0, 1'b0), 16'h0, 16'h0, 16'h0, {15'h07ea, b[0]}, b[0]);
      chk(o_flags, {15'h07ea, ~b[0]});
      chk(16'(n), 16'h0002);
    end
  endtask
  task automatic s_acc;
    for (int i = 0; i < 2; i++) begin
      fire(rq(8'(8'h3c + i), 8'h00, 16'h0081, 1'b0, 1'b0), 16'h8000, 16'h0, 16'h0, 16'h0400,
           1'b0);
      chk(o_flags, sf(16'h8000, 16'h0081, 16'h0400, i[0]));
      chk(16'(n), 16'(3 + i));
    end
  endtask
  task automatic s_grp;
    logic [15:0] b;
    for (int i = 0; i < 3; i++) begin
      b = (i == 2) ? {8'hff, 8'h80} : (i == 0) ? 16'h0080 : 16'h7f80;
      fire(rq(8'(8'h80 + i + i / 2), 8'hf8, 16'h7f80, 1'b0, 1'b0), 16'h0, 16'h0, 16'h0005,
           16'h0401, 1'b0);
      chk(o_flags, sf(16'h0005, b, 16'h0401, i != 0));
      chk(16'(n), 16'h0003);
    end
  endtask
  task automatic s_mem;
    logic [15:0] v, e;
    for (int i = 0; i < 4; i++) begin
      v = mv(16'h4321, 2'h3);
      e = i[1] ? sf(16'h9000, v, 16'h0200, i[0]) : sf(v, 16'h9000, 16'h0200, i[0]);
      fire(rq(8'(8'h38 + i), 8'h06, 16'h0, 1'b1, 1'b0), 16'h0, 16'h9000, 16'h0, 16'h0200, 1'b1);
      chk(o_flags, e);
      chk(16'(n), i[0] ? 16'h000e : 16'h000a);
      chk({15'h0, o_index_we}, 16'h0000);
    end
  endtask
  task automatic s_str;
    logic [15:0] st, f;
    for (int i = 0; i < 4; i++) begin
      st = i[0] ? 16'h0002 : 16'h0001;
      f = {5'h0, i[1], 10'h200};
      @(posedge i_clk);
      mem_wait <= 4'(i * 3);
      i_src_index <= 16'h2000;
      i_dst_index <= 16'h3002;
      fire(rq(8'(8'ha6 + i[0]), 8'h00, 16'h0, 1'b0, i[1]), 16'h0, 16'h0, 16'h0, f, i[1]);
      chk(o_flags, sf(mv(16'h2000, i[1] ? 2'h2 : 2'h3), mv(16'h3002, 2'h0), f, i[0]));
      chk(o_src_index, i[1] ? 16'h2000 - st : 16'h2000 + st);
      chk(o_dst_index, i[1] ? 16'h3002 - st : 16'h3002 + st);
      chk({15'h0, o_index_we}, 16'h0001);
      chk(16'(n), (i == 3) ? 16'h001a : 16'h0016);
    end
  endtask
  task automatic s_ill;
    logic [15:0] p;
    p = o_flags;
    fire(rq(8'h80, 8'hc0, 16'h0001, 1'b0, 1'b0), 16'h0, 16'h0, 16'h0, 16'hffff, 1'b0);
    chk({15'h0, ill}, 16'h0001);
    chk(16'(n), 16'h0028);
    chk(o_flags, p);
  endtask

  initial begin
    {i_rst, i_bus8, i_start} = 3'h4;
    i_req = '0;
    {i_acc, i_reg_val, i_rm_val, i_src_index, i_dst_index, i_flags} = '0;
    mem_wait = 4'h0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({15'h0, o_ready}, 16'h0001);
    chk(o_flags, 16'h0000);
    s_flip();
    s_acc();
    s_grp();
    s_mem();
    s_str();
    s_ill();
    complete_run();
  end
endmodule // tb_top
